// >>> rtl/sct_pkg.sv
// Constants, register map and field layout for the four-timer counter unit.
// Assumes an APB master with 32-bit data; each register uses the low byte of one word.
package sct_pkg;
    localparam int NUM_TIMERS = 4;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 10;
    localparam int PRE_W = 14;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_IMG_BASE = 8'h90;
    localparam logic [7:0] IDX_IMG_LAST = 8'h97;
    localparam logic [7:0] IDX_CNT_BASE = 8'h98;
    localparam logic [7:0] IDX_CNT_LAST = 8'h9f;
    localparam logic [7:0] IDX_CMD_BASE = 8'ha0;
    localparam logic [7:0] IDX_CMD_LAST = 8'ha3;
    localparam logic [7:0] IDX_FREEZE = 8'ha4;
    localparam logic [7:0] IDX_DLCY = 8'ha6;
    localparam logic [7:0] IDX_GLOBAL = 8'ha8;
    localparam logic [7:0] IDX_STATUS = 8'ha9;
    localparam logic [7:0] IDX_INT_MASK = 8'hd3;
    localparam logic [7:0] IDX_INT_STAT = 8'hd4;
    // Command word fields.
    localparam int CMD_MODE = 0;
    localparam int CMD_INC = 1;
    localparam int CMD_SEL = 2;
    localparam int CMD_OUT = 3;
    localparam int CMD_POL = 4;
    localparam int CMD_SRC = 5;
    localparam int CMD_LS_BLOCK = 6;
    localparam int CMD_EXT_EN = 7;
    // Global control fields.
    localparam int GLB_SCALE = 0;
    localparam int GLB_START = 1;
    localparam int GLB_MODE = 2;
    localparam int GLB_WDOG = 3;
    localparam logic [7:0] GLB_USED_MASK = 8'h0f;
    // Reset values.
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [7:0] GLB_RST = 8'h00;
    localparam logic [7:0] DLCY_RST = 8'h00;
    localparam logic [15:0] IMG_RST = 16'h0000;
    localparam logic [3:0] FLAG_RST = 4'h0;
    // Count limits and clock division.
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_MIN = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [13:0] BASE_DIV = 14'h0004;
    localparam logic [13:0] SCALE_DIV = 14'h0008;
    localparam logic [13:0] PRE_ONE = 14'h0001;
endpackage

// >>> rtl/sct_timer.sv
// One sixteen-bit counter/timer with source selection, reload and terminal count.
// Assumes tick_in is a one-cycle prescaled pulse and host writes are one-cycle strobes.
`timescale 1ns/1ps
module sct_timer (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic tick_in,
    input wire logic start_in,
    input wire logic [7:0] cmd_in,
    input wire logic [sct_pkg::CNT_W-1:0] image_in,
    input wire logic logic_event_in,
    input wire logic pin_in,
    input wire logic wr_lo_in,
    input wire logic wr_hi_in,
    input wire logic [7:0] wdata_in,
    output logic [sct_pkg::CNT_W-1:0] count_out,
    output logic tc_out,
    output logic timer_out
);
    import sct_pkg::*;

    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic src_prev_q, tc_q, out_q;
    logic src, src_rise, enabled, pulse_mode, count_up, advance, expire, load_req, host_wr;

    // Source selection, edge detection and the enable gate.
    assign src = cmd_in[CMD_SRC] ? (pin_in ^ cmd_in[CMD_POL]) : logic_event_in;
    assign src_rise = src & ~src_prev_q;
    assign enabled = cmd_in[CMD_SEL] & start_in & (~cmd_in[CMD_EXT_EN] | src);
    assign pulse_mode = cmd_in[CMD_MODE];
    assign count_up = ~pulse_mode | cmd_in[CMD_INC];
    assign advance = enabled & (pulse_mode ? tick_in : src_rise);
    assign expire = advance & (cnt_q == (count_up ? CNT_MAX : CNT_MIN));
    assign load_req = pulse_mode & src_rise & ~cmd_in[CMD_LS_BLOCK];
    assign host_wr = wr_lo_in | wr_hi_in;

    // Next count: host writes win, then reload, then the normal step.
    always_comb begin
        cnt_d = cnt_q;
        if (wr_lo_in) begin
            cnt_d[7:0] = wdata_in;
        end else if (wr_hi_in) begin
            cnt_d[15:8] = wdata_in;
        end else if ((expire & pulse_mode) | load_req) begin
            cnt_d = image_in;
        end else if (advance) begin
            cnt_d = count_up ? cnt_q + CNT_ONE : cnt_q - CNT_ONE;
        end
    end

    // Count, edge history, terminal count pulse and output level.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= CNT_MIN;
            src_prev_q <= 1'b0;
            tc_q <= 1'b0;
            out_q <= 1'b0;
        end else if (ce_in) begin
            cnt_q <= cnt_d;
            src_prev_q <= src;
            tc_q <= expire;
            out_q <= pulse_mode & cmd_in[CMD_OUT] & ~expire;
        end
    end

    assign count_out = cnt_q;
    assign tc_out = tc_q;
    assign timer_out = out_q;

    a_event_up_only: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (ce_in && !cmd_in[CMD_MODE] && !host_wr) |=>
        (cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) + CNT_ONE))
        else $error("Event mode count moved other than up by one.");

    a_pulse_reload: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (ce_in && pulse_mode && expire && !host_wr) |=> cnt_q == $past(image_in))
        else $error("Expiry in pulse mode did not reload the image.");

    a_event_no_output: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (ce_in && !cmd_in[CMD_MODE]) |=> !timer_out)
        else $error("Timer output active in event count mode.");

    a_load_blocked: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (ce_in && pulse_mode && cmd_in[CMD_LS_BLOCK] && !tick_in && !host_wr)
        |=> cnt_q == $past(cnt_q))
        else $error("Count changed while loads were blocked and no tick came.");
endmodule // sct_timer

// >>> rtl/sct_top.sv
// Four-timer counter unit with APB register access and one interrupt output.
// Assumes an APB master on sys_clk_in; timer pins and logic lines are synchronous.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module sct_top (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [sct_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [sct_pkg::NUM_TIMERS-1:0] logic_event_to_counter_n_in,
    input wire logic [sct_pkg::NUM_TIMERS-1:0] timer_pin_in,
    output logic [sct_pkg::NUM_TIMERS-1:0] timer_output_out,
    output logic [sct_pkg::NUM_TIMERS-1:0] terminal_count_outputs_out,
    output logic interrupt_request_out
);
    import sct_pkg::*;

    // Range test used by every address group decode.
    function automatic logic in_range(input logic [7:0] idx, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (idx >= lo) && (idx <= hi);
    endfunction

    logic [7:0] idx;
    logic aligned, setup, access, wr_fire, rd_fire, rd_cap;
    logic hit_img, hit_cnt, hit_cmd, hit_frz, hit_dly, hit_glb, hit_sts, hit_msk, hit_ist;
    logic hit_any;
    logic [1:0] sub_pair, sub_cmd;
    logic [7:0] wbyte;

    // Address decode; the word index is the register index.
    assign idx = paddr_in[9:2];
    assign aligned = (paddr_in[1:0] == 2'b00);
    assign hit_img = aligned & in_range(idx, IDX_IMG_BASE, IDX_IMG_LAST);
    assign hit_cnt = aligned & in_range(idx, IDX_CNT_BASE, IDX_CNT_LAST);
    assign hit_cmd = aligned & in_range(idx, IDX_CMD_BASE, IDX_CMD_LAST);
    assign hit_frz = aligned & in_range(idx, IDX_FREEZE, IDX_FREEZE);
    assign hit_dly = aligned & in_range(idx, IDX_DLCY, IDX_DLCY);
    assign hit_glb = aligned & in_range(idx, IDX_GLOBAL, IDX_GLOBAL);
    assign hit_sts = aligned & in_range(idx, IDX_STATUS, IDX_STATUS);
    assign hit_msk = aligned & in_range(idx, IDX_INT_MASK, IDX_INT_MASK);
    assign hit_ist = aligned & in_range(idx, IDX_INT_STAT, IDX_INT_STAT);
    assign hit_any = hit_img | hit_cnt | hit_cmd | hit_frz | hit_dly | hit_glb | hit_sts
                     | hit_msk | hit_ist;
    assign sub_pair = idx[2:1];
    assign sub_cmd = idx[1:0];
    assign wbyte = pwdata_in[7:0];

    // Bus phases. Read data is caught in setup so it comes from a flip-flop.
    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in;
    assign wr_fire = access & ce_in & pwrite_in & hit_any;
    assign rd_fire = access & ce_in & ~pwrite_in & hit_any;
    assign rd_cap = setup & ce_in & ~pwrite_in;
    assign pready_out = ce_in;
    assign pslverr_out = access & ~hit_any;

    // Shared control registers.
    logic [7:0] glb_q, dly_q;
    logic [3:0] frz_q, msk_q, ist_q, ist_d;
    logic [31:0] prdata_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            glb_q <= GLB_RST;
            dly_q <= DLCY_RST;
            frz_q <= FLAG_RST;
            msk_q <= FLAG_RST;
        end else if (ce_in && wr_fire) begin
            if (hit_glb) glb_q <= wbyte & GLB_USED_MASK;
            if (hit_dly) dly_q <= wbyte;
            if (hit_frz) frz_q <= wbyte[3:0];
            if (hit_msk) msk_q <= wbyte[3:0];
        end
    end

    // Prescaler: base divide by four times delay plus one, times eight if scaled.
    logic [PRE_W-1:0] pre_q, div_base, div_all, pre_lim;
    logic tick, cfg_div4;
    assign div_base = PRE_W'((PRE_W'(dly_q) + PRE_ONE) * BASE_DIV);
    assign div_all = glb_q[GLB_SCALE] ? PRE_W'(div_base * SCALE_DIV) : div_base;
    assign pre_lim = div_all - PRE_ONE;
    assign tick = (pre_q >= pre_lim);
    assign cfg_div4 = (dly_q == DLCY_RST) && !glb_q[GLB_SCALE];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pre_q <= '0;
        end else if (ce_in) begin
            pre_q <= tick ? '0 : pre_q + PRE_ONE;
        end
    end

    // Per-timer registers, freeze handshake and the timer itself.
    logic [CNT_W-1:0] img_q [NUM_TIMERS];
    logic [CNT_W-1:0] cnt_w [NUM_TIMERS];
    logic [CNT_W-1:0] shadow_q [NUM_TIMERS];
    logic [CNT_W-1:0] view_w [NUM_TIMERS];
    logic [7:0] cmd_q [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] ack_q, tc_w;

    genvar n;
    generate
        for (n = 0; n < NUM_TIMERS; n++) begin : g_timer
            logic sel_pair, sel_cmd;
            assign sel_pair = (sub_pair == 2'(n));
            assign sel_cmd = (sub_cmd == 2'(n));
            // A frozen, acknowledged timer reads from its held copy.
            assign view_w[n] = ack_q[n] ? shadow_q[n] : cnt_w[n];

            // Image, command, acknowledge and held copy of the count.
            always_ff @(posedge sys_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    img_q[n] <= IMG_RST;
                    cmd_q[n] <= CMD_RST;
                    ack_q[n] <= 1'b0;
                    shadow_q[n] <= CNT_MIN;
                end else if (ce_in) begin
                    if (wr_fire && hit_img && sel_pair && !idx[0]) img_q[n][7:0] <= wbyte;
                    if (wr_fire && hit_img && sel_pair && idx[0]) img_q[n][15:8] <= wbyte;
                    if (wr_fire && hit_cmd && sel_cmd) cmd_q[n] <= wbyte;
                    ack_q[n] <= frz_q[n];
                    if (!ack_q[n]) shadow_q[n] <= cnt_w[n];
                end
            end

            sct_timer u_timer (
                .sys_clk_in(sys_clk_in),
                .rstn_in(rstn_in),
                .ce_in(ce_in),
                .tick_in(tick),
                .start_in(glb_q[GLB_START]),
                .cmd_in(cmd_q[n]),
                .image_in(img_q[n]),
                .logic_event_in(logic_event_to_counter_n_in[n]),
                .pin_in(timer_pin_in[n]),
                .wr_lo_in(wr_fire & hit_cnt & sel_pair & ~idx[0]),
                .wr_hi_in(wr_fire & hit_cnt & sel_pair & idx[0]),
                .wdata_in(wbyte),
                .count_out(cnt_w[n]),
                .tc_out(tc_w[n]),
                .timer_out(timer_output_out[n])
            );
        end
    endgenerate

    // Read selection of the addressed byte.
    logic [CNT_W-1:0] img_sel, cnt_sel;
    logic [7:0] rbyte;
    assign img_sel = img_q[sub_pair];
    assign cnt_sel = view_w[sub_pair];
    assign rbyte = hit_img ? (idx[0] ? img_sel[15:8] : img_sel[7:0]) :
                   hit_cnt ? (idx[0] ? cnt_sel[15:8] : cnt_sel[7:0]) :
                   hit_cmd ? cmd_q[sub_cmd] :
                   hit_frz ? {4'h0, frz_q} :
                   hit_dly ? dly_q :
                   hit_glb ? glb_q :
                   hit_sts ? {4'h0, ack_q} :
                   hit_msk ? {4'h0, msk_q} :
                   hit_ist ? {4'h0, ist_q} : 8'h00;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_cap) begin
            prdata_q <= {24'h00_0000, rbyte};
        end
    end
    assign prdata_out = prdata_q;

    // Sticky interrupt status; a read clears only the bits it returned, sets win.
    assign ist_d = (ist_q & ~((rd_fire && hit_ist) ? prdata_q[3:0] : 4'h0)) | tc_w;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ist_q <= FLAG_RST;
        end else if (ce_in) begin
            ist_q <= ist_d;
        end
    end

    assign terminal_count_outputs_out = tc_w;
    assign interrupt_request_out = |(ist_q & msk_q);

    a_freeze_ack: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (ce_in && frz_q[0] && frz_q[1]) |=> (ack_q[1:0] == 2'b11))
        else $error("Freeze acknowledge flags not set after freeze.");

    a_frozen_stable: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (ack_q[0] && $past(ack_q[0])) |-> (view_w[0] == $past(view_w[0])))
        else $error("Frozen count of timer 0 changed.");

    a_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        ##1 (glb_q[7:4] == 4'h0))
        else $error("Reserved global bits hold a value.");

    a_div_by_four: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (tick && ce_in && cfg_div4) ##1 (ce_in && cfg_div4 && !tick)[*3]
        ##1 (cfg_div4) |-> tick)
        else $error("Prescaler does not divide by four at default settings.");

    a_irq_raise: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (ce_in && |(tc_w & msk_q) && !(wr_fire && hit_msk)) |=> interrupt_request_out)
        else $error("Unmasked terminal count did not raise the interrupt.");

    a_unmapped_err: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (access && !hit_any) |-> pslverr_out ##1 (glb_q == $past(glb_q) && frz_q == $past(frz_q)))
        else $error("Unmapped access not answered with an error.");
endmodule // sct_top

// >>> testbench/sct_logic_model.sv
// Behavioural model of the programmable logic that faces the four timers.
// Assumes the bench calls pulse() from one process at a time, on the system clock.
`timescale 1ns/1ps
module sct_logic_model (
    input wire logic sys_clk_in,
    input wire logic [3:0] fb_en_in,
    input wire logic [3:0] timer_output_in,
    output logic [3:0] logic_event_out,
    output logic [3:0] timer_pin_out
);
    logic [3:0] event_q = 4'h0;
    logic [3:0] pin_q = 4'h0;

    // A line in feedback mode returns the inverted timer output, otherwise generated events.
    assign logic_event_out = (fb_en_in & ~timer_output_in) | (~fb_en_in & event_q);
    assign timer_pin_out = pin_q;

    // Sends n pulses, two cycles high and three low, on one logic line or one pin.
    task pulse(input logic to_pin, input int ch, input int n);
        begin
            repeat (n) begin
                @(posedge sys_clk_in);
                if (to_pin) pin_q[ch] <= 1'b1;
                else event_q[ch] <= 1'b1;
                repeat (2) @(posedge sys_clk_in);
                if (to_pin) pin_q[ch] <= 1'b0;
                else event_q[ch] <= 1'b0;
                repeat (2) @(posedge sys_clk_in);
            end
        end
    endtask
endmodule // sct_logic_model

// >>> testbench/tb_top.sv
// Self-checking bench for the four-timer unit, driving its APB registers.
// Assumes the unit answers with zero wait states while ce_in is high.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; $display("[FAIL] %0t got %0h expected %0h", $time, (got), (exp)); end end
module tb_top;
    import sct_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rstn_in, ce_in, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pins, events, tout, tc, fb_en;
    logic [7:0] rd;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int t0, t1, t2, k;

    // Free-running 250 MHz clock and a cycle counter for period checks.
    always #2 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) cyc <= cyc + 1;

    sct_top uut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .logic_event_to_counter_n_in(events), .timer_pin_in(pins),
        .timer_output_out(tout), .terminal_count_outputs_out(tc),
        .interrupt_request_out(irq));

    sct_logic_model u_logic (.sys_clk_in(sys_clk_in), .fb_en_in(fb_en),
        .timer_output_in(tout), .logic_event_out(events), .timer_pin_out(pins));

    // One APB transfer by register index; read data and error are taken at the ready edge.
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        begin
            @(posedge sys_clk_in);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= {idx, 2'b00};
            pwdata <= {24'h000000, wd};
            @(posedge sys_clk_in);
            penable <= 1'b1;
            @(posedge sys_clk_in);
            while (pready !== 1'b1) @(posedge sys_clk_in);
            rd = prdata[7:0];
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Reads one register and compares its low byte.
    task chk_rd(input logic [7:0] idx, input logic [7:0] exp);
        begin
            apb(1'b0, idx, 8'h00);
            `CHK(rd, exp)
        end
    endtask

    // Waits for a terminal count pulse of timer 2 and returns its cycle number.
    task wait_tc(output int t);
        int n;
        begin
            n = 0;
            while (tc[2] !== 1'b1 && n < 1000) begin
                @(posedge sys_clk_in);
                n++;
            end
            if (n >= 1000) begin
                n_fail++;
                $display("[FAIL] %0t no terminal count", $time);
            end
            t = cyc;
            @(posedge sys_clk_in);
        end
    endtask

    task print_verdict;
        begin
            if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask

    // Cuts a hang short after far more time than the tests need.
    initial begin
        #200000;
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict;
    end

    // Main sequence of register accesses and timer checks.
    initial begin
        rstn_in = 1'b0;
        ce_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h00000000;
        fb_en = 4'h0;
        repeat (6) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 4; i++) chk_rd(IDX_CMD_BASE + 8'(i), CMD_RST);
        chk_rd(IDX_GLOBAL, GLB_RST);
        chk_rd(IDX_STATUS, {4'h0, FLAG_RST});
        apb(1'b1, IDX_GLOBAL, 8'hff);
        chk_rd(IDX_GLOBAL, GLB_USED_MASK);
        apb(1'b1, IDX_GLOBAL, 8'h00);
        apb(1'b0, 8'h00, 8'h00);
        `CHK(err, 1'b1)
        `CHK(rd, 8'h00)
        // A disabled timer keeps a host-written sixteen-bit count.
        apb(1'b1, IDX_CNT_BASE + 8'h06, 8'h34);
        apb(1'b1, IDX_CNT_BASE + 8'h07, 8'h12);
        chk_rd(IDX_CNT_BASE + 8'h06, 8'h34);
        chk_rd(IDX_CNT_BASE + 8'h07, 8'h12);
        // Timer 0 counts logic events, timer 1 counts pin events.
        apb(1'b1, IDX_DLCY, 8'h00);
        apb(1'b1, IDX_CMD_BASE, 8'h1e);
        apb(1'b1, IDX_CMD_BASE + 8'h01, 8'h26);
        apb(1'b1, IDX_GLOBAL, 8'h06);
        u_logic.pulse(1'b0, 0, 7);
        u_logic.pulse(1'b1, 0, 3);
        u_logic.pulse(1'b1, 1, 5);
        u_logic.pulse(1'b0, 1, 2);
        `CHK(tout[1:0], 2'b00)
        apb(1'b1, IDX_FREEZE, 8'h03);
        rd = 8'h00;
        k = 0;
        while (rd !== 8'h03 && k < 20) begin
            apb(1'b0, IDX_STATUS, 8'h00);
            k++;
        end
        `CHK(rd, 8'h03)
        u_logic.pulse(1'b0, 0, 2);
        chk_rd(IDX_CNT_BASE, 8'h07);
        chk_rd(IDX_CNT_BASE + 8'h01, 8'h00);
        chk_rd(IDX_CNT_BASE + 8'h02, 8'h05);
        chk_rd(IDX_CNT_BASE + 8'h03, 8'h00);
        apb(1'b1, IDX_FREEZE, 8'h00);
        chk_rd(IDX_STATUS, 8'h00);
        // Timer 2 in pulse mode, counting down from 3 with feedback reload.
        apb(1'b1, IDX_IMG_BASE + 8'h04, 8'h03);
        apb(1'b1, IDX_IMG_BASE + 8'h05, 8'h00);
        apb(1'b1, IDX_CNT_BASE + 8'h04, 8'h03);
        apb(1'b1, IDX_CNT_BASE + 8'h05, 8'h00);
        apb(1'b1, IDX_INT_MASK, 8'h00);
        fb_en <= 4'b0100;
        apb(1'b1, IDX_CMD_BASE + 8'h02, 8'h0d);
        wait_tc(t0);
        wait_tc(t1);
        wait_tc(t2);
        `CHK(t2 - t1, 16)
        `CHK(irq, 1'b0)
        chk_rd(IDX_INT_STAT, 8'h04);
        `CHK(tout[2], 1'b1)
        apb(1'b1, IDX_INT_MASK, 8'h04);
        wait_tc(t0);
        repeat (2) @(posedge sys_clk_in);
        `CHK(irq, 1'b1)
        chk_rd(IDX_INT_STAT, 8'h04);
        @(posedge sys_clk_in);
        `CHK(irq, 1'b0)
        // Prescale by eight stretches the period eightfold.
        apb(1'b1, IDX_GLOBAL, 8'h07);
        wait_tc(t0);
        wait_tc(t1);
        wait_tc(t2);
        `CHK(t2 - t1, 128)
        // Stopped timer 2: a source edge reloads the image only while loads may pass.
        apb(1'b1, IDX_GLOBAL, 8'h00);
        fb_en <= 4'h0;
        apb(1'b1, IDX_CNT_BASE + 8'h04, 8'h10);
        apb(1'b1, IDX_CMD_BASE + 8'h02, 8'h4d);
        u_logic.pulse(1'b0, 2, 1);
        chk_rd(IDX_CNT_BASE + 8'h04, 8'h10);
        apb(1'b1, IDX_CMD_BASE + 8'h02, 8'h0d);
        u_logic.pulse(1'b0, 2, 1);
        chk_rd(IDX_CNT_BASE + 8'h04, 8'h03);
        // Source-gated enable from the idle pin: low source holds, inverted polarity runs.
        apb(1'b1, IDX_CNT_BASE + 8'h05, 8'h01);
        apb(1'b1, IDX_CMD_BASE + 8'h02, 8'hed);
        apb(1'b1, IDX_GLOBAL, 8'h06);
        repeat (40) @(posedge sys_clk_in);
        chk_rd(IDX_CNT_BASE + 8'h05, 8'h01);
        apb(1'b1, IDX_CMD_BASE + 8'h02, 8'hfd);
        repeat (40) @(posedge sys_clk_in);
        chk_rd(IDX_CNT_BASE + 8'h05, 8'h00);
        print_verdict;
    end
endmodule // tb_top
